// *** core/pes_defines.svh ***
`ifndef PES_DEFINES_SVH
`define PES_DEFINES_SVH

////////////////////////////////////////////////////////////////////////////
// register bus and byte addresses
`define PES_AW          8
`define PES_DW          32
`define PES_REG_CTRL    8'h00
`define PES_REG_PAGES   8'h04
`define PES_REG_TIME    8'h08
`define PES_REG_STATUS  8'h0c

// control register fields and reset values
`define PES_CTRL_CAL    0
`define PES_CTRL_PAGE   1
`define PES_CTRL_TIME   2
`define PES_CTRL_W      3
`define PES_CTRL_RST    3'h1
`define PES_PAGES_W     16
`define PES_PAGES_RST   16'h0000
`define PES_TIME_W      24
`define PES_TIME_RST    24'h000000

////////////////////////////////////////////////////////////////////////////
// positions in the synchronised pin vector
`define PES_PIN_PWR     0
`define PES_PIN_DOOR    1
`define PES_PIN_PHASE   2
`define PES_PIN_PICKED  3
`define PES_PIN_FUSER   4
`define PES_PIN_STOPPED 5
`define PES_PIN_TONER   6
`define PES_PIN_CART    7
`define PES_PIN_ENV     8
`define PES_PIN_CRDONE  9
`define PES_PIN_ISDONE  10
`define PES_NPIN        11

// operating period codes
`define PES_PER_W       3
`define PES_PER_OFF     3'h0
`define PES_PER_WAIT    3'h1
`define PES_PER_STANDBY_PERIOD    3'h2
`define PES_PER_INIT    3'h3
`define PES_PER_PRINT   3'h4
`define PES_PER_FINAL   3'h5

// stabilisation time base: one tick per microsecond
`define PES_CLK_NS      4
`define PES_TICK_NS     1000
`define PES_TICK_CYC    (`PES_TICK_NS / `PES_CLK_NS)
`define PES_PRE_W       8

`endif

// *** core/pes_pkg.sv ***
`include "pes_defines.svh"

package pes_pkg;

   // sequencer states; several states share one operating period
   typedef enum logic [3:0] {
      st_off                     = 4'h0,
      st_wait_prep               = 4'h1,
      st_wait_cr                 = 4'h2,
      st_wait_is                 = 4'h3,
      st_standby_period          = 4'h4,
      st_standby_cr              = 4'h5,
      st_standby_is              = 4'h6,
      st_sleep                   = 4'h7,
      st_initial_rotation_period = 4'h8,
      st_print                   = 4'h9,
      st_final_rotation_period   = 4'ha
   } pes_state_t;

   // registered engine commands
   typedef struct packed {
      logic                  discharge;
      logic                  phase_adj;
      logic                  belt_clean;
      logic                  sense_en;
      logic                  cr_cmd;
      logic                  is_cmd;
      logic                  sleep_mode;
      logic                  drum_prep;
      logic                  deliver;
      logic                  stab_trig;
      logic [`PES_PER_W-1:0] period;
   } pes_out_t;

endpackage : pes_pkg

// *** core/pes_link_if.sv ***
`timescale 1ns/1ps
`include "pes_defines.svh"

interface pes_link_if;
   logic [`PES_NPIN-1:0]    pin_s;
   logic                    in_print;
   logic                    sheet_start;
   logic                    page_en;
   logic                    time_en;
   logic [`PES_PAGES_W-1:0] cfg_pages;
   logic [`PES_TIME_W-1:0]  cfg_time;
   logic                    stab_due;

   modport sync  (output pin_s);
   modport seq   (input pin_s, stab_due, output in_print, sheet_start,
                  page_en, time_en, cfg_pages, cfg_time);
   modport timer (input in_print, sheet_start, page_en, time_en, cfg_pages,
                  cfg_time, output stab_due);
endinterface : pes_link_if

// *** core/pes_pin_sync.sv ***
`timescale 1ns/1ps
`include "pes_defines.svh"

module pes_pin_sync (
   input wire logic                 core_clk,
   input wire logic                 rst_b,
   input wire logic [`PES_NPIN-1:0] pins,
   pes_link_if.sync                 link
);
   typedef struct packed {
      logic [`PES_NPIN-1:0] s1;
      logic [`PES_NPIN-1:0] s2;
   } pes_sync_t;

   pes_sync_t s_r;
   pes_sync_t s_nxt;

   // first stage feeds only the second stage
   always_comb begin
      s_nxt.s1 = pins;
      s_nxt.s2 = s_r.s1;
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) s_r <= '0;
      else        s_r <= s_nxt;
   end

   assign link.pin_s = s_r.s2;
endmodule : pes_pin_sync

// *** core/pes_stab_timer.sv ***
`timescale 1ns/1ps
`include "pes_defines.svh"

module pes_stab_timer (
   input wire logic core_clk,
   input wire logic rst_b,
   pes_link_if.timer link
);
   typedef struct packed {
      logic [`PES_PRE_W-1:0]   pre;
      logic [`PES_TIME_W-1:0]  tcnt;
      logic [`PES_PAGES_W-1:0] pcnt;
      logic                    due;
   } pes_tmr_t;

   pes_tmr_t s_r;
   pes_tmr_t s_nxt;

   // print time only advances during the print period, so idle time
   // between jobs does not force extra stabilisation cycles
   always_comb begin
      s_nxt     = s_r;
      s_nxt.due = 1'b0;
      if (link.in_print) begin
         if (s_r.pre == `PES_PRE_W'(`PES_TICK_CYC - 1)) begin
            s_nxt.pre  = '0;
            s_nxt.tcnt = s_r.tcnt + 1'b1;
         end else begin
            s_nxt.pre = s_r.pre + 1'b1;
         end
         if (link.time_en && link.cfg_time != '0 &&
             s_r.tcnt >= link.cfg_time) begin
            s_nxt.due  = 1'b1;
            s_nxt.tcnt = '0;
            s_nxt.pre  = '0;
         end
      end
      // sheet count interval, counted as each sheet starts printing
      if (link.sheet_start) begin
         s_nxt.pcnt = s_r.pcnt + 1'b1;
         if (link.page_en && link.cfg_pages != '0 &&
             s_nxt.pcnt >= link.cfg_pages) begin
            s_nxt.due  = 1'b1;
            s_nxt.pcnt = '0;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) s_r <= '0;
      else        s_r <= s_nxt;
   end

   assign link.stab_due = s_r.due;
endmodule : pes_stab_timer

// *** core/pes_seq.sv ***
// Contract
// (R1) power-up or door closure enters wait; stay until drum phase is done
// (R2) wait commands drum discharge, drum phase adjust, transfer belt clean
// (R3) wait samples toner, cartridge, environment; runs calibration first
// (R4) standby follows wait or final rotation; holds until print or off
// (R5) sleep command in standby puts the engine into sleep mode
// (R6) standby runs color registration or stability on formatter command
// (R7) print command enters initial rotation until media is picked up
// (R8) print period follows initial rotation until fuser trailing edge
// (R9) print period triggers stabilisation at set sheet or time interval
// (R10) final rotation follows print, ends when delivery motor stops
// (R11) print command in final rotation goes straight to initial rotation
// (R12) current operating period is shown on an encoded output
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "pes_defines.svh"

module pes_seq (
   input  wire logic                  core_clk,
   input  wire logic                  rst_b,
   // register port
   input  wire logic [`PES_AW-1:0]    reg_addr,
   input  wire logic [`PES_DW-1:0]    reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output logic      [`PES_DW-1:0]    reg_rdata,
   // engine pins, asynchronous
   input  wire logic                  power_good,
   input  wire logic                  door_closed,
   input  wire logic                  phase_done,
   input  wire logic                  media_picked,
   input  wire logic                  fuser_paper,
   input  wire logic                  deliver_stopped,
   input  wire logic                  toner_low,
   input  wire logic                  cart_present,
   input  wire logic                  env_ok,
   input  wire logic                  cr_done,
   input  wire logic                  is_done,
   // formatter commands, one-cycle pulses on core_clk
   input  wire logic                  fmt_print_req,
   input  wire logic                  fmt_sleep_req,
   input  wire logic                  fmt_cr_req,
   input  wire logic                  fmt_is_req,
   // engine commands and period code
   output logic      [`PES_PER_W-1:0] period_code,
   output logic                       drum_discharge,
   output logic                       drum_phase_adj,
   output logic                       transfer_belt_clean,
   output logic                       sense_en,
   output logic                       cr_cmd,
   output logic                       is_cmd,
   output logic                       sleep_mode,
   output logic                       drum_prep,
   output logic                       deliver_run,
   output logic                       stab_trig
);

   ////////////////////////////////////////////////////////////////////////
   // state record

   typedef struct packed {
      pes_pkg::pes_state_t     st;
      logic                    fuser_q;
      logic                    print_pend;
      logic                    toner;
      logic                    cart;
      logic                    env;
      logic [`PES_CTRL_W-1:0]  ctrl;
      logic [`PES_PAGES_W-1:0] pages;
      logic [`PES_TIME_W-1:0]  stime;
      logic [`PES_DW-1:0]      rdata;
      pes_pkg::pes_out_t       out;
   } pes_seq_t;

   pes_seq_t             s_r;
   pes_seq_t             s_nxt;
   logic                 ok;
   logic                 go;
   logic                 enter_init;
   logic                 trail_edge;
   logic [`PES_NPIN-1:0] pin;

   pes_link_if link ();

   ////////////////////////////////////////////////////////////////////////
   // helpers

   // operating period of a state
   function automatic logic [`PES_PER_W-1:0] period_of(
      input pes_pkg::pes_state_t st);
      case (st)
         pes_pkg::st_wait_prep,
         pes_pkg::st_wait_cr,
         pes_pkg::st_wait_is:               period_of = `PES_PER_WAIT;
         pes_pkg::st_standby_period,
         pes_pkg::st_standby_cr,
         pes_pkg::st_standby_is,
         pes_pkg::st_sleep:                 period_of = `PES_PER_STANDBY_PERIOD;
         pes_pkg::st_initial_rotation_period:
                                            period_of = `PES_PER_INIT;
         pes_pkg::st_print:                 period_of = `PES_PER_PRINT;
         pes_pkg::st_final_rotation_period: period_of = `PES_PER_FINAL;
         default:                           period_of = `PES_PER_OFF;
      endcase
   endfunction : period_of

   // engine commands for a state; stab_trig is filled in separately
   function automatic pes_pkg::pes_out_t outs_of(
      input pes_pkg::pes_state_t st);
      logic w;
      w                  = period_of(st) == `PES_PER_WAIT;
      outs_of            = '0;
      outs_of.discharge  = w;                              // [R2]
      outs_of.belt_clean = w;                              // [R2]
      outs_of.sense_en   = w;                              // [R3]
      outs_of.phase_adj  = st == pes_pkg::st_wait_prep;    // [R2]
      outs_of.cr_cmd     = st == pes_pkg::st_wait_cr ||
                           st == pes_pkg::st_standby_cr;   // [R6]
      outs_of.is_cmd     = st == pes_pkg::st_wait_is ||
                           st == pes_pkg::st_standby_is;   // [R6]
      outs_of.sleep_mode = st == pes_pkg::st_sleep;        // [R5]
      outs_of.drum_prep  = st == pes_pkg::st_initial_rotation_period;
      outs_of.deliver    = st == pes_pkg::st_final_rotation_period;
      outs_of.period     = period_of(st);                  // [R12]
   endfunction : outs_of

   ////////////////////////////////////////////////////////////////////////
   // sub-blocks

   pes_pin_sync u_sync (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .pins     ({is_done, cr_done, env_ok, cart_present, toner_low,
                  deliver_stopped, fuser_paper, media_picked, phase_done,
                  door_closed, power_good}),
      .link     (link)
   );

   pes_stab_timer u_timer (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .link     (link)
   );

   // qualified pin views; fuser sensor low after high is the trailing edge
   assign pin        = link.pin_s;
   assign ok         = pin[`PES_PIN_PWR] & pin[`PES_PIN_DOOR];
   assign trail_edge = s_r.fuser_q & ~pin[`PES_PIN_FUSER];

   // timer setup; a sheet counts on entering print so its trigger stays
   // inside the print period, not after the trailing edge [R9]
   assign link.in_print    = s_r.st == pes_pkg::st_print;
   assign link.sheet_start = s_nxt.st == pes_pkg::st_print & ~link.in_print;
   assign link.page_en     = s_r.ctrl[`PES_CTRL_PAGE];
   assign link.time_en     = s_r.ctrl[`PES_CTRL_TIME];
   assign link.cfg_pages   = s_r.pages;
   assign link.cfg_time    = s_r.stime;

   ////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      s_nxt   = s_r;
      go      = fmt_print_req | s_r.print_pend;
      s_nxt.fuser_q = pin[`PES_PIN_FUSER];
      case (s_r.st)
         // power or door returns: start the wait period
         pes_pkg::st_off: begin
            s_nxt.st = pes_pkg::st_wait_prep;                   // [R1]
         end
         pes_pkg::st_wait_prep: begin
            if (pin[`PES_PIN_PHASE]) begin                      // [R1]
               if (s_r.ctrl[`PES_CTRL_CAL])
                  s_nxt.st = pes_pkg::st_wait_cr;               // [R3]
               else
                  s_nxt.st = pes_pkg::st_standby_period;        // [R4]
            end
         end
         pes_pkg::st_wait_cr: begin
            if (pin[`PES_PIN_CRDONE]) s_nxt.st = pes_pkg::st_wait_is;
         end
         pes_pkg::st_wait_is: begin
            if (pin[`PES_PIN_ISDONE])
               s_nxt.st = pes_pkg::st_standby_period;           // [R3] [R4]
         end
         // print wins over sleep, sleep over calibration
         pes_pkg::st_standby_period: begin
            if (go)
               s_nxt.st = pes_pkg::st_initial_rotation_period;  // [R7]
            else if (fmt_sleep_req)
               s_nxt.st = pes_pkg::st_sleep;                    // [R5]
            else if (fmt_cr_req)
               s_nxt.st = pes_pkg::st_standby_cr;               // [R6]
            else if (fmt_is_req)
               s_nxt.st = pes_pkg::st_standby_is;               // [R6]
         end
         pes_pkg::st_standby_cr: begin
            if (pin[`PES_PIN_CRDONE])
               s_nxt.st = pes_pkg::st_standby_period;
         end
         pes_pkg::st_standby_is: begin
            if (pin[`PES_PIN_ISDONE])
               s_nxt.st = pes_pkg::st_standby_period;
         end
         pes_pkg::st_sleep: begin
            if (go)
               s_nxt.st = pes_pkg::st_initial_rotation_period;  // [R7]
         end
         pes_pkg::st_initial_rotation_period: begin
            if (pin[`PES_PIN_PICKED]) s_nxt.st = pes_pkg::st_print; // [R8]
         end
         pes_pkg::st_print: begin
            if (trail_edge)
               s_nxt.st = pes_pkg::st_final_rotation_period;    // [R8] [R10]
         end
         pes_pkg::st_final_rotation_period: begin
            if (go)
               s_nxt.st = pes_pkg::st_initial_rotation_period;  // [R11]
            else if (pin[`PES_PIN_STOPPED])
               s_nxt.st = pes_pkg::st_standby_period;           // [R4] [R10]
         end
         default: s_nxt.st = pes_pkg::st_off;
      endcase

      // power loss or an open door overrides everything
      if (!ok) s_nxt.st = pes_pkg::st_off;                      // [R1] [R4]

      // a print command is kept until used or until power or door loss: loss wins over a new command, one is used per entry
      enter_init = s_nxt.st == pes_pkg::st_initial_rotation_period &&
                   s_r.st != pes_pkg::st_initial_rotation_period;
      if (!ok)
         s_nxt.print_pend = 1'b0;
      else if (enter_init)
         s_nxt.print_pend = s_r.print_pend & fmt_print_req;
      else
         s_nxt.print_pend = s_r.print_pend | fmt_print_req;

      // consumables and environment tracked only during wait
      if (period_of(s_r.st) == `PES_PER_WAIT) begin                  // [R3]
         s_nxt.toner = pin[`PES_PIN_TONER];
         s_nxt.cart  = pin[`PES_PIN_CART];
         s_nxt.env   = pin[`PES_PIN_ENV];
      end

      // commands are registered so the pins never glitch on decode
      s_nxt.out           = outs_of(s_nxt.st);
      s_nxt.out.stab_trig = link.stab_due & link.in_print &
                            s_nxt.st == pes_pkg::st_print;          // [R9]

      // register writes
      if (reg_wr) begin
         case (reg_addr)
            `PES_REG_CTRL:  s_nxt.ctrl  = reg_wdata[`PES_CTRL_W-1:0];
            `PES_REG_PAGES: s_nxt.pages = reg_wdata[`PES_PAGES_W-1:0];
            `PES_REG_TIME:  s_nxt.stime = reg_wdata[`PES_TIME_W-1:0];
            default: ;
         endcase
      end

      // read data stands for one cycle only; unmapped reads give zero
      s_nxt.rdata = '0;
      if (reg_rd) begin
         case (reg_addr)
            `PES_REG_CTRL:   s_nxt.rdata = `PES_DW'(s_r.ctrl);
            `PES_REG_PAGES:  s_nxt.rdata = `PES_DW'(s_r.pages);
            `PES_REG_TIME:   s_nxt.rdata = `PES_DW'(s_r.stime);
            `PES_REG_STATUS: s_nxt.rdata = `PES_DW'({s_r.env, s_r.cart,
                                s_r.toner, s_r.print_pend, s_r.out.period,
                                s_r.st});                           // [R12]
            default:         s_nxt.rdata = '0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_r       <= '0;
         s_r.st    <= pes_pkg::st_off;
         s_r.ctrl  <= `PES_CTRL_RST;
         s_r.pages <= `PES_PAGES_RST;
         s_r.stime <= `PES_TIME_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // outputs straight from flip-flops
   assign reg_rdata           = s_r.rdata;
   assign period_code         = s_r.out.period;                     // [R12]
   assign drum_discharge      = s_r.out.discharge;
   assign drum_phase_adj      = s_r.out.phase_adj;
   assign transfer_belt_clean = s_r.out.belt_clean;
   assign sense_en            = s_r.out.sense_en;
   assign cr_cmd              = s_r.out.cr_cmd;
   assign is_cmd              = s_r.out.is_cmd;
   assign sleep_mode          = s_r.out.sleep_mode;
   assign drum_prep           = s_r.out.drum_prep;
   assign deliver_run         = s_r.out.deliver;
   assign stab_trig           = s_r.out.stab_trig;

   ////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   a_wait_entry: assert property (                                  // [R1]
      s_r.st == pes_pkg::st_off && ok |=>
         s_r.st == pes_pkg::st_wait_prep ##0 drum_phase_adj)
      else $error("power or door return did not start wait");

   a_wait_hold: assert property (                                   // [R1]
      s_r.st == pes_pkg::st_wait_prep && ok && !pin[`PES_PIN_PHASE] |=>
         period_code == `PES_PER_WAIT)
      else $error("wait left before drum phase done");

   a_wait_cmds: assert property (                                   // [R2]
      period_code == `PES_PER_WAIT |->
         drum_discharge && transfer_belt_clean && sense_en)
      else $error("wait period commands missing");

   a_cal_first: assert property (                                   // [R3]
      s_r.st == pes_pkg::st_wait_prep && ok && pin[`PES_PIN_PHASE] &&
      s_r.ctrl[`PES_CTRL_CAL] |=> cr_cmd && !is_cmd)
      else $error("wait calibration skipped");

   a_standby_period_from: assert property (                                   // [R4]
      $rose(period_code == `PES_PER_STANDBY_PERIOD) |->
         $past(period_code) == `PES_PER_WAIT ||
         $past(period_code) == `PES_PER_FINAL)
      else $error("standby entered from wrong period");

   a_sleep_cmd: assert property (                                   // [R5]
      s_r.st == pes_pkg::st_standby_period && ok && !go &&
      fmt_sleep_req |=> sleep_mode ##1 (sleep_mode || $past(!ok || go)))
      else $error("sleep command not obeyed");

   a_cr_cmd: assert property (                                      // [R6]
      s_r.st == pes_pkg::st_standby_period && ok && !go &&
      !fmt_sleep_req && fmt_cr_req |=> cr_cmd)
      else $error("standby color registration not started");

   a_init_hold: assert property (                                   // [R7]
      s_r.st == pes_pkg::st_initial_rotation_period && ok &&
      !pin[`PES_PIN_PICKED] |=> drum_prep)
      else $error("initial rotation left before pickup");

   a_print_end: assert property (                                   // [R8]
      s_r.st == pes_pkg::st_print && ok && trail_edge |=>
         period_code == `PES_PER_FINAL && deliver_run)
      else $error("trailing edge did not end print period");

   a_stab_trig: assert property (                                   // [R9]
      stab_trig |-> period_code == `PES_PER_PRINT &&
         $past(link.stab_due))
      else $error("stabilisation trigger outside print");

   a_final_hold: assert property (                                  // [R10]
      s_r.st == pes_pkg::st_final_rotation_period && ok && !go &&
      !pin[`PES_PIN_STOPPED] |=> deliver_run)
      else $error("final rotation ended early");

   a_reprint: assert property (                                     // [R11]
      s_r.st == pes_pkg::st_final_rotation_period && ok &&
      fmt_print_req |=> period_code == `PES_PER_INIT)
      else $error("reprint passed through standby");

   a_period_code: assert property (                                 // [R12]
      period_code == period_of(s_r.st))
      else $error("period code does not match state");

endmodule : pes_seq

// *** verification/pes_fmt_model.sv ***
`timescale 1ns/1ps

module pes_fmt_model (
   input  wire logic core_clk,
   output logic      fmt_print_req,
   output logic      fmt_sleep_req,
   output logic      fmt_cr_req,
   output logic      fmt_is_req
);
   initial {fmt_print_req, fmt_sleep_req, fmt_cr_req, fmt_is_req} = 4'h0;

   // one-cycle command pulse; 0 print, 1 sleep, 2 colour reg, 3 stability
   // print may come in any period, also final rotation
   task send(input int k);
      @(posedge core_clk);
      {fmt_is_req, fmt_cr_req, fmt_sleep_req, fmt_print_req} <= 4'h1 << k;
      @(posedge core_clk);
      {fmt_is_req, fmt_cr_req, fmt_sleep_req, fmt_print_req} <= 4'h0;
   endtask : send
endmodule : pes_fmt_model

// *** verification/pes_seq_bench.sv ***
`timescale 1ns/1ps
`include "pes_defines.svh"

module pes_seq_bench;
   logic core_clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
   logic power_good = 1, door_closed = 1, phase_done = 0, media_picked = 0;
   logic fuser_paper = 0, deliver_stopped = 0, toner_low = 0;
   logic cart_present = 1, env_ok = 1, cr_done = 0, is_done = 0;
   logic fmt_print_req, fmt_sleep_req, fmt_cr_req, fmt_is_req;
   logic [2:0] period_code;
   logic drum_discharge, drum_phase_adj, transfer_belt_clean, sense_en;
   logic cr_cmd, is_cmd, sleep_mode, drum_prep, deliver_run, stab_trig;
   int n_fail = 0, cmp_count = 0, n_stab = 0;

   pes_fmt_model fmt (.core_clk, .fmt_print_req, .fmt_sleep_req,
      .fmt_cr_req, .fmt_is_req);
   pes_seq dut (.core_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .power_good, .door_closed, .phase_done, .media_picked,
      .fuser_paper, .deliver_stopped, .toner_low, .cart_present, .env_ok,
      .cr_done, .is_done, .fmt_print_req, .fmt_sleep_req, .fmt_cr_req,
      .fmt_is_req, .period_code, .drum_discharge, .drum_phase_adj,
      .transfer_belt_clean, .sense_en, .cr_cmd, .is_cmd, .sleep_mode,
      .drum_prep, .deliver_run, .stab_trig);

   initial forever #2 core_clk = ~core_clk;
   // a pulse lasts one cycle, so count it on every rising edge
   always @(posedge core_clk) if (stab_trig === 1'b1) n_stab++;

   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: %h expected %h", $time, got, exp);
      end
   endtask : chk

   task wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge core_clk);
      {reg_addr, reg_wdata, reg_wr} <= {a, v, 1'b1};
      @(posedge core_clk);
      reg_wr <= 0;
   endtask : wr

   // read data stand only in the cycle after the strobe
   task rd(input logic [7:0] a);
      @(posedge core_clk);
      {reg_addr, reg_rd} <= {a, 1'b1};
      @(posedge core_clk);
      reg_rd <= 0;
      #1 d = reg_rdata;
   endtask : rd

   // bounded wait for a period, then compare it
   task wp(input logic [2:0] p);
      for (int i = 0; i < 40 && period_code !== p; i++)
         @(posedge core_clk) #1;
      chk(period_code, p);
   endtask : wp

   // one sheet from pickup to the fuser trailing edge
   task sheet;
      wp(`PES_PER_INIT); chk(drum_prep, 1);
      media_picked <= 1; fuser_paper <= 1;
      wp(`PES_PER_PRINT);
      media_picked <= 0; fuser_paper <= 0;
      wp(`PES_PER_FINAL); chk(deliver_run, 1);
   endtask : sheet

   task conclude;
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : conclude

   initial begin
      #200000 n_fail++;
      conclude;
   end

   initial begin
      repeat (10) @(posedge core_clk);
      rst_b <= 1;
      rd(`PES_REG_CTRL); chk(d, 32'h1);
      rd(8'h40); chk(d, 32'h0);
      wp(`PES_PER_WAIT);
      chk({drum_discharge, drum_phase_adj, transfer_belt_clean}, 3'h7);
      phase_done <= 1;
      repeat (3) @(posedge core_clk) #1;
      chk({sense_en, cr_cmd}, 2'h3);
      cr_done <= 1;
      repeat (6) @(posedge core_clk) #1;
      chk({cr_cmd, is_cmd}, 2'h1);
      is_done <= 1;
      wp(`PES_PER_STANDBY_PERIOD);
      {cr_done, is_done} <= 2'h0;
      $display("test wait done");
      // standby calibrations, then sleep
      for (int k = 2; k < 4; k++) begin
         repeat (4) @(posedge core_clk);
         fmt.send(k);
         #1 chk({cr_cmd, is_cmd}, (k == 2) ? 2'h2 : 2'h1);
         {cr_done, is_done} <= 2'h3;
         repeat (6) @(posedge core_clk);
         {cr_done, is_done} <= 2'h0;
      end
      repeat (4) @(posedge core_clk);
      fmt.send(1);
      #1 chk(sleep_mode, 1);
      $display("test standby done");
      wr(`PES_REG_PAGES, 32'h1);
      wr(`PES_REG_CTRL, 32'h3);
      fmt.send(0);
      sheet;
      repeat (3) @(posedge core_clk);
      chk(n_stab, 1);
      fmt.send(0);
      sheet;
      deliver_stopped <= 1;
      wp(`PES_PER_STANDBY_PERIOD);
      chk(n_stab, 2);
      $display("test print done");
      door_closed <= 0;
      wp(`PES_PER_OFF);
      door_closed <= 1;
      wp(`PES_PER_WAIT);
      rd(`PES_REG_STATUS); chk(d[6:4], `PES_PER_WAIT);
      chk(d[10:8], 3'h6);
      $display("test door done");
      conclude;
   end
endmodule : pes_seq_bench
